// ==== rtl/stm_pkg.sv ====
package stm_pkg;
	localparam logic [7:0] ERR_BUS_RESET = 8'h27;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ACK_VALUE = 8'h02;
	localparam int SEL_REC_WORDS = 8;
	localparam logic [2:0] REC_LAST = 3'h7;
	localparam int AVAIL_BIT = 0;
	localparam int TGT_EN_BIT = 1;
	localparam logic [3:0] HCMD_BOARD = 4'h1;
	localparam logic [3:0] HCMD_PASS = 4'h2;
	localparam logic [3:0] HCMD_TEN = 4'h3;
	localparam logic [3:0] HCMD_TDIS = 4'h4;
	localparam logic [3:0] HCMD_TRESP = 4'h5;
	localparam logic [7:0] MSG_IDE = 8'h05;
	localparam logic [7:0] MSG_MPE = 8'h09;
	localparam logic [7:0] MSG_SDTR = 8'h01;
	localparam logic [4:0] DEV_TYPE_RST = 5'h00;
	typedef enum logic [2:0] {
		STM_IDLE,
		STM_WRREC,
		STM_IRQ,
		STM_FETCH,
		STM_RESEL,
		STM_STAT
	} stm_state_t;
endpackage : stm_pkg

// ==== rtl/stm_wr_if.sv ====
`timescale 1ns/10ps
interface stm_wr_if;
	logic start;
	logic [31:0] base;
	logic [7:0] flags;
	logic [7:0] err;
	logic [31:0] info;
	logic busy;
	logic done;
	modport ctl (output start, output base, output flags, output err, output info,
		input busy, input done);
	modport eng (input start, input base, input flags, input err, input info,
		output busy, output done);
endinterface : stm_wr_if

// ==== rtl/stm_rec_writer.sv ====
`timescale 1ns/10ps
module stm_rec_writer (
	input wire logic clk_in,
	input wire logic rst_in,
	stm_wr_if.eng wr,
	output logic mem_we_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_data_out
);
	logic [2:0] idx_ff;
	logic busy_ff;
	logic done_ff;
	logic [31:0] word;
	// flags word carries the semaphore; it goes last so the host never sees a half record
	assign word = (idx_ff == stm_pkg::REC_LAST) ? {16'h0000, wr.err, wr.flags} :
		(idx_ff == 3'h0) ? wr.info : 32'h0000_0000;
	assign wr.busy = busy_ff;
	assign wr.done = done_ff;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			idx_ff <= 3'h0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= 32'h0000_0000;
			mem_data_out <= 32'h0000_0000;
		end else begin
			done_ff <= busy_ff && idx_ff == stm_pkg::REC_LAST;
			mem_we_out <= busy_ff;
			mem_addr_out <= wr.base + {27'h0, idx_ff, 2'h0};
			mem_data_out <= word;
			if (wr.start && !busy_ff) begin
				busy_ff <= 1'b1;
				idx_ff <= 3'h0;
			end else if (busy_ff) begin
				idx_ff <= idx_ff + 3'h1;
				if (idx_ff == stm_pkg::REC_LAST) begin
					busy_ff <= 1'b0;
				end
			end
		end
	end
endmodule : stm_rec_writer

// ==== rtl/stm_target_ctrl.sv ====
`timescale 1ns/10ps
// Function
// - target, initiator, or both concurrently
// - board and pass-through commands in target mode
// - accept selection, start reselection when enabled
// - initiator duties continue while target enabled
// - answer as host-chosen device type
// - record address only from enable command
// - on selection write record, then interrupt
// - response command fetches block, answers initiator
// - completion returns status block with extras
// - forward messages except error/parity and SDTR ones
// - negotiate and handle parity locally
// - disconnect every selection until enabled
// - set selection-available flag in semaphore
// - bus reset: rewrite record, error 27H
module stm_target_ctrl (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CMD_VALID_IN,
	input wire logic [3:0] CMD_CODE_IN,
	input wire logic [31:0] CMD_ADDR_IN,
	input wire logic [4:0] CMD_DEVTYPE_IN,
	input wire logic ATTN_WE_IN,
	input wire logic [7:0] ATTN_DATA_IN,
	input wire logic SEL_IN,
	input wire logic [7:0] SEL_INFO_IN,
	input wire logic RESEL_IN,
	input wire logic BUS_RST_IN,
	input wire logic MSG_VALID_IN,
	input wire logic [7:0] MSG_IN,
	input wire logic PARITY_ERR_IN,
	input wire logic RESP_DONE_IN,
	input wire logic [31:0] RESP_INFO_IN,
	output logic MEM_WE_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	output logic [31:0] MEM_DATA_OUT,
	output logic IRQ_OUT,
	output logic SEL_ACCEPT_OUT,
	output logic SEL_DISCONNECT_OUT,
	output logic RESEL_START_OUT,
	output logic INIT_CMD_OUT,
	output logic INIT_RESEL_ACK_OUT,
	output logic [4:0] DEVTYPE_OUT,
	output logic MSG_FWD_OUT,
	output logic [7:0] MSG_FWD_DATA_OUT,
	output logic MSG_LOCAL_OUT,
	output logic FETCH_REQ_OUT,
	output logic [31:0] FETCH_ADDR_OUT,
	output logic STATUS_OUT,
	output logic [31:0] STATUS_INFO_OUT
);
	stm_pkg::stm_state_t state_ff, nxt_state;
	logic enabled_ff;
	logic [31:0] rec_base_ff;
	logic [31:0] resp_addr_ff;
	logic ack_pend_ff;
	logic [7:0] rec_flags_ff;
	logic [7:0] rec_err_ff;
	logic [31:0] rec_info_ff;
	logic start_ff;
	logic resp_pend_ff;
	logic [31:0] resp_info_ff;
	logic [1:0] wr_kind_ff;
	logic term_pend_ff;
	logic [7:0] term_err_ff;
	stm_wr_if wr ();
	assign wr.start = start_ff;
	assign wr.base = rec_base_ff;
	assign wr.flags = rec_flags_ff;
	assign wr.err = rec_err_ff;
	assign wr.info = rec_info_ff;
	stm_rec_writer u_wr (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr(wr),
		.mem_we_out(MEM_WE_OUT),
		.mem_addr_out(MEM_ADDR_OUT),
		.mem_data_out(MEM_DATA_OUT)
	);
	wire cmd_ten = CMD_VALID_IN && CMD_CODE_IN == stm_pkg::HCMD_TEN;
	wire cmd_tdis = CMD_VALID_IN && CMD_CODE_IN == stm_pkg::HCMD_TDIS;
	wire cmd_resp = CMD_VALID_IN && CMD_CODE_IN == stm_pkg::HCMD_TRESP;
	wire cmd_init = CMD_VALID_IN && (CMD_CODE_IN == stm_pkg::HCMD_BOARD ||
		CMD_CODE_IN == stm_pkg::HCMD_PASS);
	wire ack_hit = ATTN_WE_IN && ATTN_DATA_IN == stm_pkg::ACK_VALUE;
	wire sel_take = SEL_IN && enabled_ff && !BUS_RST_IN && state_ff == stm_pkg::STM_IDLE
		&& !ack_pend_ff;
	// a selection that cannot be recorded now is dropped off the bus; no queue kept
	wire sel_drop = SEL_IN && !sel_take;
	wire msg_local = MSG_VALID_IN && (MSG_IN == stm_pkg::MSG_IDE || MSG_IN == stm_pkg::MSG_MPE
		|| MSG_IN == stm_pkg::MSG_SDTR);
	wire end_target = enabled_ff && (BUS_RST_IN || cmd_tdis);
	// an end seen while busy is held here, so its record is still written once idle
	wire term_go = state_ff == stm_pkg::STM_IDLE && !sel_take
		&& (end_target || term_pend_ff);
	wire [7:0] term_err_now = BUS_RST_IN ? stm_pkg::ERR_BUS_RESET : stm_pkg::ERR_NONE;
	wire fetch_go = state_ff == stm_pkg::STM_IDLE && nxt_state == stm_pkg::STM_FETCH;
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			stm_pkg::STM_IDLE: begin
				if (sel_take) begin
					nxt_state = stm_pkg::STM_WRREC;
				end else if (term_go) begin
					nxt_state = stm_pkg::STM_WRREC;
				end else if (resp_pend_ff && enabled_ff) begin
					nxt_state = stm_pkg::STM_FETCH;
				end
			end
			stm_pkg::STM_WRREC: begin
				if (wr.done) begin
					nxt_state = (wr_kind_ff == 2'h0) ? stm_pkg::STM_IRQ : stm_pkg::STM_IDLE;
				end
			end
			stm_pkg::STM_IRQ: nxt_state = stm_pkg::STM_IDLE;
			stm_pkg::STM_FETCH: nxt_state = stm_pkg::STM_RESEL;
			stm_pkg::STM_RESEL: begin
				if (RESP_DONE_IN || BUS_RST_IN) begin
					nxt_state = stm_pkg::STM_STAT;
				end
			end
			stm_pkg::STM_STAT: nxt_state = stm_pkg::STM_IDLE;
		endcase
	end
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_ff <= stm_pkg::STM_IDLE;
			enabled_ff <= 1'b0;
			rec_base_ff <= 32'h0000_0000;
			resp_addr_ff <= 32'h0000_0000;
			ack_pend_ff <= 1'b0;
			rec_flags_ff <= 8'h00;
			rec_err_ff <= 8'h00;
			rec_info_ff <= 32'h0000_0000;
			start_ff <= 1'b0;
			resp_pend_ff <= 1'b0;
			resp_info_ff <= 32'h0000_0000;
			wr_kind_ff <= 2'h0;
			term_pend_ff <= 1'b0;
			term_err_ff <= 8'h00;
			DEVTYPE_OUT <= stm_pkg::DEV_TYPE_RST;
		end else begin
			state_ff <= nxt_state;
			start_ff <= 1'b0;
			if (cmd_ten) begin
				enabled_ff <= 1'b1;
				rec_base_ff <= CMD_ADDR_IN;
				DEVTYPE_OUT <= CMD_DEVTYPE_IN;
			end else if (end_target) begin
				enabled_ff <= 1'b0;
			end
			if (sel_take) begin
				start_ff <= 1'b1;
				wr_kind_ff <= 2'h0;
				rec_info_ff <= {24'h000000, SEL_INFO_IN};
				rec_err_ff <= stm_pkg::ERR_NONE;
				rec_flags_ff <= (8'h01 << stm_pkg::AVAIL_BIT)
					| (8'h01 << stm_pkg::TGT_EN_BIT);
			end else if (term_go) begin
				// termination record: enabled flag cleared, bus reset tagged
				start_ff <= 1'b1;
				wr_kind_ff <= 2'h1;
				rec_flags_ff <= 8'h00;
				rec_err_ff <= end_target ? term_err_now : term_err_ff;
			end
			// set wins; kept apart so a termination never swallows an ack
			if (sel_take) begin
				ack_pend_ff <= 1'b1;
			end else if (ack_hit) begin
				ack_pend_ff <= 1'b0;
			end
			if (end_target && !term_go) begin
				term_pend_ff <= 1'b1;
				term_err_ff <= term_err_now;
			end else if (term_go) begin
				term_pend_ff <= 1'b0;
			end
			// a response arriving as the previous one is taken stays queued
			if (cmd_resp) begin
				resp_pend_ff <= 1'b1;
				resp_addr_ff <= CMD_ADDR_IN;
			end else if (fetch_go) begin
				resp_pend_ff <= 1'b0;
			end
			if (state_ff == stm_pkg::STM_RESEL) begin
				if (RESP_DONE_IN) begin
					resp_info_ff <= RESP_INFO_IN;
				end else if (BUS_RST_IN) begin
					resp_info_ff <= 32'h0000_0000;
				end
			end
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			IRQ_OUT <= 1'b0;
			SEL_ACCEPT_OUT <= 1'b0;
			SEL_DISCONNECT_OUT <= 1'b0;
			RESEL_START_OUT <= 1'b0;
			INIT_CMD_OUT <= 1'b0;
			INIT_RESEL_ACK_OUT <= 1'b0;
			MSG_FWD_OUT <= 1'b0;
			MSG_FWD_DATA_OUT <= 8'h00;
			MSG_LOCAL_OUT <= 1'b0;
			FETCH_REQ_OUT <= 1'b0;
			FETCH_ADDR_OUT <= 32'h0000_0000;
			STATUS_OUT <= 1'b0;
			STATUS_INFO_OUT <= 32'h0000_0000;
		end else begin
			IRQ_OUT <= state_ff == stm_pkg::STM_IRQ;
			SEL_ACCEPT_OUT <= sel_take;
			SEL_DISCONNECT_OUT <= sel_drop;
			RESEL_START_OUT <= state_ff == stm_pkg::STM_FETCH;
			INIT_CMD_OUT <= cmd_init;
			INIT_RESEL_ACK_OUT <= RESEL_IN;
			MSG_FWD_OUT <= MSG_VALID_IN && !msg_local;
			MSG_FWD_DATA_OUT <= MSG_IN;
			MSG_LOCAL_OUT <= msg_local || PARITY_ERR_IN;
			FETCH_REQ_OUT <= fetch_go;
			FETCH_ADDR_OUT <= resp_addr_ff;
			STATUS_OUT <= state_ff == stm_pkg::STM_STAT;
			STATUS_INFO_OUT <= resp_info_ff;
		end
	end
	sequence sel_seq;
		sel_take ##1 start_ff;
	endsequence
	irq_after_rec_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		sel_seq |-> ##[9:12] IRQ_OUT) else $error("no interrupt after record");
	no_sel_off_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(SEL_IN && !enabled_ff) |=> SEL_DISCONNECT_OUT && !SEL_ACCEPT_OUT)
		else $error("selection not dropped while disabled");
	avail_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		sel_take |=> rec_flags_ff[stm_pkg::AVAIL_BIT] && rec_flags_ff[stm_pkg::TGT_EN_BIT])
		else $error("flag not set");
	rst_err_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(BUS_RST_IN && enabled_ff && state_ff == stm_pkg::STM_IDLE && !cmd_ten)
		|=> rec_err_ff == stm_pkg::ERR_BUS_RESET && !rec_flags_ff[stm_pkg::TGT_EN_BIT]
		&& !enabled_ff && start_ff)
		else $error("bus reset record wrong");
	base_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!cmd_ten |=> $stable(rec_base_ff)) else $error("record base moved");
	msg_filter_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(MSG_VALID_IN && (MSG_IN == stm_pkg::MSG_IDE || MSG_IN == stm_pkg::MSG_MPE))
		|=> !MSG_FWD_OUT && MSG_LOCAL_OUT) else $error("error message forwarded");
	fetch_resel_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		FETCH_REQ_OUT |-> FETCH_ADDR_OUT == $past(resp_addr_ff) ##1 RESEL_START_OUT)
		else $error("fetch not followed by reselect");
	init_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		cmd_init |=> INIT_CMD_OUT) else $error("initiator command lost");
	ack_clear_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(ack_hit && !sel_take) |=> !ack_pend_ff) else $error("ack ignored");
endmodule : stm_target_ctrl

// ==== testbench/stm_initiator_model.sv ====
`timescale 1ns/10ps
// remote initiators; idle data lines show the inverse of their last value
module stm_initiator_model (
	input wire logic clk_in,
	output logic sel_out,
	output logic [7:0] info_out,
	output logic resel_out,
	output logic bus_rst_out,
	output logic msg_valid_out,
	output logic [7:0] msg_out,
	output logic parity_err_out,
	output logic done_out,
	output logic [31:0] resp_info_out
);
	logic [5:0] strb = 6'h00;
	assign {done_out, parity_err_out, msg_valid_out, bus_rst_out, resel_out, sel_out} = strb;
	initial begin
		{info_out, msg_out} = 16'h0000;
		resp_info_out = 32'h0;
	end
	task automatic pulse(input logic [5:0] k, input logic [31:0] d);
		@(posedge clk_in);
		strb <= k;
		info_out <= d[7:0];
		msg_out <= d[7:0];
		resp_info_out <= d;
		@(posedge clk_in);
		strb <= 6'h00;
		info_out <= ~d[7:0];
		msg_out <= ~d[7:0];
		resp_info_out <= ~d;
	endtask : pulse
endmodule : stm_initiator_model

// ==== testbench/test_stm_target_ctrl.sv ====
`timescale 1ns/10ps
module test_stm_target_ctrl;
	typedef struct packed {logic [3:0] k; logic [63:0] v; logic [63:0] m;} stm_exp_t;
	stm_exp_t q[$];
	int n_fail = 0;
	int n_tests = 0;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_v = 1'b0;
	logic [3:0] cmd_c = 4'h0;
	logic [31:0] cmd_a = 32'h0;
	logic [4:0] cmd_d = 5'h00;
	logic attn_we = 1'b0;
	logic [7:0] attn_d = 8'h00;
	logic sel, resel, brst, msg_v, perr, rdone;
	logic [7:0] sinfo, msg, fdata;
	logic [31:0] rinfo, maddr, mdata, faddr, base, a, d, stinfo;
	logic mem_we, irq, acc, disc, rstart, icmd, rack, fwd, loc, fetch, stat;
	logic [4:0] devt;
	logic [7:0] mb[4];
	always #20 clk = ~clk;
	stm_target_ctrl i_dut (.CLK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(cmd_v), .CMD_CODE_IN(cmd_c),
		.CMD_ADDR_IN(cmd_a), .CMD_DEVTYPE_IN(cmd_d), .ATTN_WE_IN(attn_we), .ATTN_DATA_IN(attn_d),
		.SEL_IN(sel), .SEL_INFO_IN(sinfo), .RESEL_IN(resel), .BUS_RST_IN(brst),
		.MSG_VALID_IN(msg_v), .MSG_IN(msg), .PARITY_ERR_IN(perr), .RESP_DONE_IN(rdone),
		.RESP_INFO_IN(rinfo), .MEM_WE_OUT(mem_we), .MEM_ADDR_OUT(maddr), .MEM_DATA_OUT(mdata),
		.IRQ_OUT(irq), .SEL_ACCEPT_OUT(acc), .SEL_DISCONNECT_OUT(disc), .RESEL_START_OUT(rstart),
		.INIT_CMD_OUT(icmd), .INIT_RESEL_ACK_OUT(rack), .DEVTYPE_OUT(devt), .MSG_FWD_OUT(fwd),
		.MSG_FWD_DATA_OUT(fdata), .MSG_LOCAL_OUT(loc), .FETCH_REQ_OUT(fetch),
		.FETCH_ADDR_OUT(faddr), .STATUS_OUT(stat), .STATUS_INFO_OUT(stinfo));
	stm_initiator_model i_init (.clk_in(clk), .sel_out(sel), .info_out(sinfo), .resel_out(resel),
		.bus_rst_out(brst), .msg_valid_out(msg_v), .msg_out(msg), .parity_err_out(perr),
		.done_out(rdone), .resp_info_out(rinfo));
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic note(input logic [3:0] k, input logic [63:0] v = '0, input logic [63:0] m = '0);
		q.push_back('{k, v, m});
	endtask : note
	task automatic take(input logic [3:0] k, input logic [63:0] v);
		stm_exp_t e;
		e = '{4'hF, 64'h0, 64'h0};
		if (q.size() != 0)
			e = q.pop_front();
		chk("output kind", {60'h0, k}, {60'h0, e.k});
		chk("output value", v & e.m, e.v & e.m);
	endtask : take
	// one pulse per cycle in these scenarios, so a fixed scan order is safe
	always @(negedge clk) if (!rst) begin
		if (acc === 1'b1) take(4'h1, 64'h0);
		if (disc === 1'b1) take(4'h2, 64'h0);
		if (mem_we === 1'b1) take(4'h3, {maddr, mdata});
		if (irq === 1'b1) take(4'h4, 64'h0);
		if (icmd === 1'b1) take(4'h5, 64'h0);
		if (rack === 1'b1) take(4'h6, 64'h0);
		if (fwd === 1'b1) take(4'h7, {56'h0, fdata});
		if (loc === 1'b1) take(4'h8, 64'h0);
		if (fetch === 1'b1) take(4'h9, {32'h0, faddr});
		if (rstart === 1'b1) take(4'hA, 64'h0);
		if (stat === 1'b1) take(4'hB, {32'h0, stinfo});
	end
	task automatic rec(input logic [31:0] w0, input logic [31:0] w7, input logic [31:0] m0,
		input logic [31:0] m7);
		for (int i = 0; i < 8; i++)
			note(4'h3, {base + 32'(4 * i), i == 0 ? w0 : i == 7 ? w7 : 32'h0},
				{32'hFFFFFFFF, i == 7 ? m7 : m0});
	endtask : rec
	task automatic cmd(input logic [3:0] c, input logic [31:0] ad);
		@(posedge clk);
		cmd_v <= 1'b1;
		cmd_c <= c;
		cmd_a <= ad;
		cmd_d <= ad[11:7];
		@(posedge clk);
		cmd_v <= 1'b0;
	endtask : cmd
	task automatic ack;
		@(posedge clk);
		attn_we <= 1'b1;
		attn_d <= stm_pkg::ACK_VALUE;
		@(posedge clk);
		attn_we <= 1'b0;
	endtask : ack
	task automatic settle;
		for (int i = 0; i < 40 && q.size() != 0; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		// an expected output that never came counts as a mismatch
		chk("pending outputs", 64'(q.size()), 64'h0);
	endtask : settle
	task automatic select(input logic ok);
		logic [7:0] inf;
		inf = 8'($urandom);
		if (ok) begin
			note(4'h1);
			rec({24'h0, inf}, {16'h0, stm_pkg::ERR_NONE, 8'h03}, '1, '1);
			note(4'h4);
		end else
			note(4'h2);
		i_init.pulse(6'h01, {24'h0, inf});
		settle();
	endtask : select
	task automatic resp(input logic [31:0] ad);
		note(4'h9, {32'h0, ad}, '1);
		note(4'hA);
		cmd(stm_pkg::HCMD_TRESP, ad);
		settle();
	endtask : resp
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
	initial begin
		void'($urandom(16));
		mb = '{stm_pkg::MSG_IDE, stm_pkg::MSG_MPE, stm_pkg::MSG_SDTR, 8'h07};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		select(1'b0);
		base = $urandom & 32'hFFFFFFE0;
		cmd(stm_pkg::HCMD_TEN, base);
		settle();
		chk("device type", {59'h0, devt}, {59'h0, base[11:7]});
		select(1'b1);
		select(1'b0);
		ack();
		select(1'b1);
		for (int i = 0; i < 4; i++) begin
			note(i < 3 ? 4'h8 : 4'h7, {56'h0, mb[i]}, i < 3 ? 64'h0 : 64'hFF);
			i_init.pulse(6'h08, {24'h0, mb[i]});
			settle();
		end
		note(4'h8);
		i_init.pulse(6'h10, 32'h0);
		settle();
		note(4'h5);
		cmd(stm_pkg::HCMD_BOARD, 32'h0);
		note(4'h5);
		cmd(stm_pkg::HCMD_PASS, 32'h0);
		note(4'h6);
		i_init.pulse(6'h02, 32'h0);
		settle();
		ack();
		a = $urandom;
		resp(a);
		d = $urandom;
		note(4'hB, {32'h0, d}, '1);
		i_init.pulse(6'h20, d);
		settle();
		rec(32'h0, {16'h0, stm_pkg::ERR_NONE, 8'h00}, 32'h0, 32'hFF02);
		cmd(stm_pkg::HCMD_TDIS, 32'h0);
		settle();
		select(1'b0);
		base = $urandom & 32'hFFFFFFE0;
		cmd(stm_pkg::HCMD_TEN, base);
		settle();
		rec(32'h0, {16'h0, stm_pkg::ERR_BUS_RESET, 8'h00}, 32'h0, 32'hFF02);
		i_init.pulse(6'h04, 32'h0);
		settle();
		// bus reset while a response is under way: record still rewritten afterwards
		base = $urandom & 32'hFFFFFFE0;
		cmd(stm_pkg::HCMD_TEN, base);
		settle();
		a = $urandom;
		resp(a);
		note(4'hB, 64'h0, '1);
		rec(32'h0, {16'h0, stm_pkg::ERR_BUS_RESET, 8'h00}, 32'h0, 32'hFF02);
		i_init.pulse(6'h04, 32'h0);
		settle();
		end_of_test();
	end
endmodule : test_stm_target_ctrl
